// file: rtl/pwos_pkg.sv
// Constants and carrier types for the pressure window, trim and filter status block.
// Assumes a byte-wide register port driven by the serial interface front end.
// What this block does
// - Threshold and trim writes accepted only until the init-done lock is set.
// - Thresholds and trim feed the read/write register array error check.
// - Upper threshold at 46h/47h, lower at 48h/49h, all reset to zero.
// - Thresholds compare as independent unsigned 16-bit values.
// - A zero threshold skips its own comparison; the other still works.
// - Both thresholds zero disables the interrupt output.
// - Trim at 4Ch/4Dh is signed 16-bit, added to calibrated pressure.
// - Any trim change resets the filter path; results invalid until reinit done.
// - Self-test-never-run bit 3 set at reset, cleared by any self-test control bit.
// - Self-test-running bit 2 is the OR of the four control bits.
// - Common-mode fault bit 1 set on limit breach, cleared by read or transmission.
// - Self-test fault bit 0 set on failure, cleared only by reset.
// - Sense bit 0 fires outside window, 1 fires inside window.
// - With zero stretch the pin follows the last evaluated sample's condition.
package pwos_pkg;
  localparam logic [7:0] PWOS_ADDR_UPPER_LO = 8'h46;
  localparam logic [7:0] PWOS_ADDR_UPPER_HI = 8'h47;
  localparam logic [7:0] PWOS_ADDR_LOWER_LO = 8'h48;
  localparam logic [7:0] PWOS_ADDR_LOWER_HI = 8'h49;
  localparam logic [7:0] PWOS_ADDR_TRIM_LO = 8'h4c;
  localparam logic [7:0] PWOS_ADDR_TRIM_HI = 8'h4d;
  localparam logic [7:0] PWOS_ADDR_STATUS = 8'h60;
  localparam logic [7:0] PWOS_BYTE_RESET = 8'h00;
  localparam logic [15:0] PWOS_THRESH_OFF = 16'h0000;
  localparam int PWOS_BIT_NEVER_RUN = 3;
  localparam int PWOS_BIT_RUNNING = 2;
  localparam int PWOS_BIT_CM_FAULT = 1;
  localparam int PWOS_BIT_ST_FAULT = 0;
  localparam logic [7:0] PWOS_STATUS_RESET = 8'h08;
  localparam int PWOS_REINIT_CYCLES = 64;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pwos_req_t;

  typedef struct packed {
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] trim;
  } pwos_cfg_t;
endpackage

// file: rtl/pwos_window.sv
// Window comparator and interrupt pin for the pressure thresholds.
// Assumes sample_valid pulses once per evaluated pressure sample.
`timescale 1ns/1ns
module pwos_window (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  input wire logic [15:0] upper,
  input wire logic [15:0] lower,
  input wire logic sense_inside,
  output logic irq
);
  import pwos_pkg::*;
  logic upper_on;
  logic lower_on;
  logic outside;
  logic cond;
  logic next_irq;

  always_comb begin
    upper_on = (upper != PWOS_THRESH_OFF);
    lower_on = (lower != PWOS_THRESH_OFF);
    outside = (upper_on && (sample > upper)) || (lower_on && (sample < lower));
    cond = sense_inside ? !outside : outside;
    if (!upper_on && !lower_on) begin
      cond = 1'b0;
    end
    next_irq = sample_valid ? cond : irq;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end
endmodule

// file: rtl/pwos_regs.sv
// Threshold, trim and filter status registers of the pressure sensor core.
// Assumes a same-clock byte register port; sensor inputs come from on-chip logic.
`timescale 1ns/1ns
module pwos_regs #(
  parameter int REINIT_CYCLES = pwos_pkg::PWOS_REINIT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire pwos_pkg::pwos_req_t req,
  output logic [7:0] rdata,
  input wire logic init_done_lock,
  input wire logic sense_inside,
  input wire logic [3:0] selftest_control,
  input wire logic selftest_fail,
  input wire logic cm_out_of_limits,
  input wire logic cm_reported,
  input wire logic cal_valid,
  input wire logic [15:0] cal_pressure,
  output logic [15:0] pressure_result,
  output logic result_valid,
  output logic filter_reset,
  output pwos_pkg::pwos_cfg_t cfg_array,
  output logic irq
);
  import pwos_pkg::*;
  pwos_cfg_t cfg;
  pwos_cfg_t next_cfg;
  logic never_run, next_never_run;
  logic cm_fault, next_cm_fault;
  logic st_fault, next_st_fault;
  logic [15:0] next_result;
  logic next_result_valid;
  logic [7:0] next_rdata;
  logic [7:0] status;
  logic trim_changed;
  logic wr_ok;
  logic [$clog2(REINIT_CYCLES+1)-1:0] reinit_cnt, next_reinit_cnt;

  always_comb begin
    next_cfg = cfg;
    wr_ok = req.wr && !init_done_lock;
    if (wr_ok) begin
      case (req.addr)
        PWOS_ADDR_UPPER_LO: next_cfg.upper[7:0] = req.wdata;
        PWOS_ADDR_UPPER_HI: next_cfg.upper[15:8] = req.wdata;
        PWOS_ADDR_LOWER_LO: next_cfg.lower[7:0] = req.wdata;
        PWOS_ADDR_LOWER_HI: next_cfg.lower[15:8] = req.wdata;
        PWOS_ADDR_TRIM_LO: next_cfg.trim[7:0] = req.wdata;
        PWOS_ADDR_TRIM_HI: next_cfg.trim[15:8] = req.wdata;
        default: next_cfg = cfg;
      endcase
    end
    trim_changed = (next_cfg.trim != cfg.trim);
  end

  always_comb begin
    status = 8'h00;
    status[PWOS_BIT_NEVER_RUN] = never_run;
    status[PWOS_BIT_RUNNING] = |selftest_control;
    status[PWOS_BIT_CM_FAULT] = cm_fault;
    status[PWOS_BIT_ST_FAULT] = st_fault;
    next_never_run = never_run && !(|selftest_control);
    next_st_fault = st_fault || selftest_fail;
    next_cm_fault = cm_fault;
    if ((req.rd && req.addr == PWOS_ADDR_STATUS) || cm_reported) begin
      next_cm_fault = 1'b0;
    end
    if (cm_out_of_limits) begin
      next_cm_fault = 1'b1;
    end
    case (req.addr)
      PWOS_ADDR_UPPER_LO: next_rdata = cfg.upper[7:0];
      PWOS_ADDR_UPPER_HI: next_rdata = cfg.upper[15:8];
      PWOS_ADDR_LOWER_LO: next_rdata = cfg.lower[7:0];
      PWOS_ADDR_LOWER_HI: next_rdata = cfg.lower[15:8];
      PWOS_ADDR_TRIM_LO: next_rdata = cfg.trim[7:0];
      PWOS_ADDR_TRIM_HI: next_rdata = cfg.trim[15:8];
      PWOS_ADDR_STATUS: next_rdata = status;
      default: next_rdata = 8'h00;
    endcase
    if (!req.rd) begin
      next_rdata = rdata;
    end
  end

  always_comb begin
    next_reinit_cnt = reinit_cnt;
    next_result = pressure_result;
    next_result_valid = 1'b0;
    if (trim_changed) begin
      next_reinit_cnt = ($clog2(REINIT_CYCLES+1))'(REINIT_CYCLES);
    end else if (reinit_cnt != '0) begin
      next_reinit_cnt = reinit_cnt - 1'b1;
    end else if (cal_valid) begin
      next_result = cal_pressure + cfg.trim;
      next_result_valid = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg <= '0;
      never_run <= 1'b1;
      cm_fault <= 1'b0;
      st_fault <= 1'b0;
      rdata <= PWOS_BYTE_RESET;
      reinit_cnt <= '0;
      pressure_result <= 16'h0000;
      result_valid <= 1'b0;
    end else begin
      cfg <= next_cfg;
      never_run <= next_never_run;
      cm_fault <= next_cm_fault;
      st_fault <= next_st_fault;
      rdata <= next_rdata;
      reinit_cnt <= next_reinit_cnt;
      pressure_result <= next_result;
      result_valid <= next_result_valid;
    end
  end

  assign filter_reset = (reinit_cnt != '0);
  assign cfg_array = cfg;

  pwos_window u_window (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_valid(result_valid),
    .sample(pressure_result),
    .upper(cfg.upper),
    .lower(cfg.lower),
    .sense_inside(sense_inside),
    .irq(irq)
  );
endmodule

// file: dv/pwos_host.sv
// Host model issuing byte register accesses.
// Drives req just after rising clk; waits out filter reinit.
`timescale 1ns/1ns
module pwos_host (
  input logic clk,
  input logic [7:0] rdata,
  input logic filter_reset,
  output pwos_pkg::pwos_req_t req
);
  import pwos_pkg::*;
  initial req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    // Look at filter_reset off the edge, where it has settled
    for (int n = 0; n < 40 && filter_reset; n++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1 req = {w, !w, a, d};
    @(posedge clk);
    #1 req = {2'b00, ~a, ~d};
    @(posedge clk);
    #1 q = rdata;
  endtask
endmodule

// file: dv/pwos_checker.sv
// Assertions on pwos_regs ports.
// Bound to every pwos_regs instance.
`timescale 1ns/1ns
module pwos_checker (
  input logic clk,
  input logic sys_rst,
  input pwos_pkg::pwos_req_t req,
  input logic init_done_lock,
  input logic sense_inside,
  input logic cal_valid,
  input logic [15:0] cal_pressure,
  input logic [15:0] pressure_result,
  input logic result_valid,
  input logic filter_reset,
  input pwos_pkg::pwos_cfg_t cfg_array,
  input logic irq
);
  import pwos_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_lock_wr: assert property (init_done_lock && req.wr |=> $stable(cfg_array)) else $error("lock");
  chk_upper_map: assert property (req.wr && !init_done_lock && req.addr == PWOS_ADDR_UPPER_LO
    |=> cfg_array.upper[7:0] == $past(req.wdata)) else $error("map");
  chk_trim_reinit: assert property ($changed(cfg_array.trim) |-> ##[0:1] filter_reset) else $error("reinit");
  chk_reinit_mute: assert property (filter_reset |=> !result_valid) else $error("mute");
  chk_trim_sum: assert property (cal_valid && !filter_reset
    && !(req.wr && !init_done_lock && (req.addr == PWOS_ADDR_TRIM_LO || req.addr == PWOS_ADDR_TRIM_HI))
    |=> result_valid && pressure_result == $past(cal_pressure) + $past(cfg_array.trim)) else $error("sum");
  chk_irq_hold: assert property (!result_valid |=> $stable(irq)) else $error("hold");
  chk_irq_off: assert property (result_valid && cfg_array.upper == PWOS_THRESH_OFF
    && cfg_array.lower == PWOS_THRESH_OFF |=> !irq) else $error("off");
  chk_irq_above: assert property (result_valid && cfg_array.upper != PWOS_THRESH_OFF
    && pressure_result > cfg_array.upper |=> irq != $past(sense_inside)) else $error("above");
endmodule
bind pwos_regs pwos_checker u_chk (.clk, .sys_rst, .req, .init_done_lock, .sense_inside, .cal_valid,
  .cal_pressure, .pressure_result, .result_valid, .filter_reset, .cfg_array, .irq);

// file: dv/pwos_tb_top.sv
// Bench for pwos_regs: registers, trim, window and status.
// Host model issues accesses; bench drives sensor inputs.
`timescale 1ns/1ns
module pwos_tb_top;
  import pwos_pkg::*;
  logic clk, sys_rst, init_done_lock, sense_inside, selftest_fail, cm_out_of_limits, cm_reported, cal_valid;
  logic result_valid, filter_reset, irq;
  logic [3:0] selftest_control;
  logic [7:0] rdata, q;
  logic [15:0] cal_pressure, pressure_result;
  pwos_req_t req;
  pwos_cfg_t cfg_array;
  logic [7:0] map [8] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4c, 8'h4d, 8'h60, 8'h50};
  int err_total = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  pwos_regs #(.REINIT_CYCLES(4)) dut (.clk, .sys_rst, .req, .rdata, .init_done_lock, .sense_inside,
    .selftest_control, .selftest_fail, .cm_out_of_limits, .cm_reported, .cal_valid, .cal_pressure,
    .pressure_result, .result_valid, .filter_reset, .cfg_array, .irq);
  pwos_host host (.clk, .rdata, .filter_reset, .req);
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, q);
    chk("reg", {8'h00, q}, {8'h00, e});
  endtask
  task automatic smp(input logic [15:0] p, input logic [15:0] e, input logic ei);
    repeat (6) @(posedge clk);
    #1 cal_pressure = p;
    cal_valid = 1'b1;
    @(posedge clk);
    #1 cal_valid = 1'b0;
    chk("valid", {15'h0, result_valid}, 16'h0001);
    @(posedge clk);
    #1 chk("result", pressure_result, e);
    chk("irq", {15'h0, irq}, {15'h0, ei});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    {clk, sys_rst, init_done_lock, sense_inside, selftest_fail, cm_out_of_limits, cm_reported, cal_valid} = 8'h40;
    selftest_control = 4'h0;
    cal_pressure = 16'h0000;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    foreach (map[i]) rd(map[i], map[i] == PWOS_ADDR_STATUS ? PWOS_STATUS_RESET : PWOS_BYTE_RESET);
    host.acc(1'b1, 8'h46, 8'h5a, q);
    rd(8'h46, 8'h5a);
    host.acc(1'b1, 8'h47, 8'h10, q);
    host.acc(1'b1, 8'h49, 8'h08, q);
    host.acc(1'b1, 8'h4d, 8'hff, q);
    chk("filter_reset", {15'h0, filter_reset}, 16'h0001);
    cal_valid = 1'b1;
    @(posedge clk);
    #1 cal_valid = 1'b0;
    chk("mute", {15'h0, result_valid}, 16'h0000);
    host.acc(1'b1, 8'h4c, 8'hfe, q);
    chk("cfg_trim", cfg_array.trim, 16'hfffe);
    rd(8'h47, 8'h10);
    rd(8'h4d, 8'hff);
    smp(16'h1100, 16'h10fe, 1'b1);
    smp(16'h0c00, 16'h0bfe, 1'b0);
    smp(16'h0700, 16'h06fe, 1'b1);
    sense_inside = 1'b1;
    smp(16'h0c00, 16'h0bfe, 1'b1);
    sense_inside = 1'b0;
    host.acc(1'b1, 8'h47, 8'h00, q);
    host.acc(1'b1, 8'h46, 8'h00, q);
    smp(16'hf000, 16'heffe, 1'b0);
    smp(16'h0100, 16'h00fe, 1'b1);
    host.acc(1'b1, 8'h49, 8'h00, q);
    smp(16'h0100, 16'h00fe, 1'b0);
    init_done_lock = 1'b1;
    host.acc(1'b1, 8'h46, 8'h55, q);
    rd(8'h46, 8'h00);
    selftest_fail = 1'b1;
    cm_out_of_limits = 1'b1;
    @(posedge clk);
    #1 selftest_fail = 1'b0;
    cm_out_of_limits = 1'b0;
    rd(8'h60, 8'h0b);
    rd(8'h60, 8'h09);
    selftest_control = 4'h8;
    rd(8'h60, 8'h05);
    selftest_control = 4'h0;
    rd(8'h60, 8'h01);
    // Second reset in mid-run clears the sticky self-test fault
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(8'h60, 8'h08);
    chk("cfg_trim_rst", cfg_array.trim, 16'h0000);
    cm_out_of_limits = 1'b1;
    rd(8'h60, 8'h0a);
    cm_out_of_limits = 1'b0;
    rd(8'h60, 8'h0a);
    rd(8'h60, 8'h08);
    cm_out_of_limits = 1'b1;
    @(posedge clk);
    #1 cm_out_of_limits = 1'b0;
    cm_reported = 1'b1;
    @(posedge clk);
    #1 cm_reported = 1'b0;
    rd(8'h60, 8'h08);
    tally_and_finish;
  end
endmodule
